// *** hdl/scan_port_pkg.sv ***
// constants shared by the scan-port controller, its checker and its bench
// assumes a single 25 MHz system clock samples the test clock pin
package scan_port_pkg;
   localparam int          INSTR_WIDTH      = 8;
   localparam int          CELL_COUNT       = 48;
   localparam int          CONTROL_WIDTH    = 3;
   localparam int          IDENT_WIDTH      = 32;
   localparam logic [7:0]  INSTR_RESET      = 8'h81;
   localparam logic [7:0]  INSTR_CAPTURE    = 8'h81;
   localparam logic [2:0]  CONTROL_RESET    = 3'h2;
   localparam int          ENABLE_CELL_LOW  = 44;
   localparam int          ENABLE_CELL_HIGH = 47;
   // opcodes of the implemented instructions, bit 7 being parity
   localparam logic [6:0]  OP_EXTEST        = 7'h00;
   localparam logic [6:0]  OP_IDCODE        = 7'h01;
   localparam logic [6:0]  OP_SAMPLE        = 7'h02;
   localparam logic [6:0]  OP_RUNT          = 7'h09;
   localparam logic [6:0]  OP_CONTROL_SCAN  = 7'h0A;
   // identity value is arbitrary
   localparam logic [31:0] IDENT_DEFAULT    = 32'h0000_1001;
   localparam logic [2:0]  OPER_SIGNATURE   = 3'h2;
   localparam logic [2:0]  OPER_COUNT       = 3'h6;

   typedef enum logic [3:0] {
      TEST_LOGIC_RESET, RUN_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
      PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR,
      EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
   } tap_state_t;

   typedef enum logic [1:0] {SEL_BOUNDARY, SEL_CONTROL, SEL_BYPASS, SEL_IDENT} data_sel_t;
endpackage

// *** hdl/link_edge_finder.sv ***
// synchronises the test pins and reports test-clock edges
// assumes pins are asynchronous to clk; test clock well under clk/4
`timescale 1ns/1ps
module link_edge_finder (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic testClockPin,
   input  wire logic modeSelectPin,
   input  wire logic dataInPin,
   output logic      riseTick,
   output logic      fallTick,
   output logic      modeSelect,
   output logic      dataIn
);
   // ----------------------------------------
   // two-stage synchronisers
   // ----------------------------------------
   logic [2:0] meta;
   logic [2:0] sync;
   logic       clockLast;

   // pins idle high; resetting to that level keeps a false edge away
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta      <= 3'h7;
         sync      <= 3'h7;
         clockLast <= 1'b1;
      end else begin
         meta      <= {modeSelectPin, dataInPin, testClockPin};
         sync      <= meta;
         clockLast <= sync[0];
      end
   end

   // ----------------------------------------
   // edge pulses
   // ----------------------------------------
   assign riseTick   = sync[0] & ~clockLast;
   assign fallTick   = ~sync[0] & clockLast;
   assign modeSelect = sync[2];
   assign dataIn     = sync[1];
endmodule // link_edge_finder

// *** hdl/boundary_scan_tap_controller.sv ***
// test access port controller with instruction and four data registers
// assumes the test clock runs far slower than clk and is sampled here
`timescale 1ns/1ps
module boundary_scan_tap_controller
   import scan_port_pkg::*;
#(
   parameter logic [31:0] IDENT_VALUE = scan_port_pkg::IDENT_DEFAULT
) (
   input  wire logic                                  clk,
   input  wire logic                                  rst,
   input  wire logic                                  testClock,
   input  wire logic                                  modeSelect,
   input  wire logic                                  testDataIn,
   input  wire logic [scan_port_pkg::CELL_COUNT-1:0]  pinSample,
   output logic                                       testDataOut,
   output logic                                       testDataOutEn,
   output logic                                       testMode,
   output logic [scan_port_pkg::CELL_COUNT-1:0]       cellDrive,
   output logic [scan_port_pkg::INSTR_WIDTH-1:0]      activeInstr,
   output logic [scan_port_pkg::CONTROL_WIDTH-1:0]    operation,
   output logic                                       parallelSignatureMode,
   output scan_port_pkg::tap_state_t                  tapState
);
   import scan_port_pkg::*;

   // ----------------------------------------
   // pin synchronisation and edges
   // ----------------------------------------
   logic rise;
   logic fall;
   logic tms;
   logic tdi;

   link_edge_finder edges (
      .clk           (clk),
      .rst           (rst),
      .testClockPin  (testClock),
      .modeSelectPin (modeSelect),
      .dataInPin     (testDataIn),
      .riseTick      (rise),
      .fallTick      (fall),
      .modeSelect    (tms),
      .dataIn        (tdi)
   );

   // ----------------------------------------
   // state machine
   // ----------------------------------------
   tap_state_t next_state;

   always_comb begin
      case (tapState)
         TEST_LOGIC_RESET: next_state = tms ? TEST_LOGIC_RESET : RUN_IDLE;
         RUN_IDLE:         next_state = tms ? SELECT_DR : RUN_IDLE;
         SELECT_DR:        next_state = tms ? SELECT_IR : CAPTURE_DR;
         CAPTURE_DR:       next_state = tms ? EXIT1_DR : SHIFT_DR;
         SHIFT_DR:         next_state = tms ? EXIT1_DR : SHIFT_DR;
         EXIT1_DR:         next_state = tms ? UPDATE_DR : PAUSE_DR;
         // pause holds until host moves on
         PAUSE_DR:         next_state = tms ? EXIT2_DR : PAUSE_DR;
         EXIT2_DR:         next_state = tms ? UPDATE_DR : SHIFT_DR;
         UPDATE_DR:        next_state = tms ? SELECT_DR : RUN_IDLE;
         SELECT_IR:        next_state = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
         CAPTURE_IR:       next_state = tms ? EXIT1_IR : SHIFT_IR;
         SHIFT_IR:         next_state = tms ? EXIT1_IR : SHIFT_IR;
         EXIT1_IR:         next_state = tms ? UPDATE_IR : PAUSE_IR;
         PAUSE_IR:         next_state = tms ? EXIT2_IR : PAUSE_IR;
         EXIT2_IR:         next_state = tms ? UPDATE_IR : SHIFT_IR;
         UPDATE_IR:        next_state = tms ? SELECT_DR : RUN_IDLE;
         default:          next_state = TEST_LOGIC_RESET;
      endcase
   end

   // advance on test-clock rise only; power-up in reset state
   // the graph returns to reset within five high cycles
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tapState <= TEST_LOGIC_RESET;
      end else if (rise) begin
         tapState <= next_state;
      end
   end

   // ----------------------------------------
   // instruction decode
   // ----------------------------------------
   logic [INSTR_WIDTH-1:0] instrShift;
   logic                   parityOk;
   logic [6:0]             opcode;
   data_sel_t              dataSel;
   logic                   isExtest;
   logic                   isRunt;
   logic                   isSample;

   // bad parity or unknown opcode falls back to bypass
   assign parityOk = ~(^activeInstr);
   assign opcode   = activeInstr[6:0];
   assign isExtest = parityOk && (opcode == OP_EXTEST);
   assign isSample = parityOk && (opcode == OP_SAMPLE);
   assign isRunt   = parityOk && (opcode == OP_RUNT);
   assign dataSel  = (isExtest || isSample)                      ? SEL_BOUNDARY :
                     (parityOk && opcode == OP_IDCODE)           ? SEL_IDENT :
                     (parityOk && opcode == OP_CONTROL_SCAN)     ? SEL_CONTROL :
                                                                   SEL_BYPASS;

   // ----------------------------------------
   // per-state strobes
   // ----------------------------------------
   logic resetRise;
   logic resetFall;
   logic captureDrRise;
   logic captureIrRise;
   logic shiftDrRise;
   logic shiftIrRise;
   logic updateDrFall;
   logic updateIrFall;

   // one-clk strobes keep the register processes below short
   assign resetRise     = rise && (tapState == TEST_LOGIC_RESET);
   assign resetFall     = fall && (tapState == TEST_LOGIC_RESET);
   assign captureDrRise = rise && (tapState == CAPTURE_DR);
   assign captureIrRise = rise && (tapState == CAPTURE_IR);
   assign shiftDrRise   = rise && (tapState == SHIFT_DR);
   assign shiftIrRise   = rise && (tapState == SHIFT_IR);
   assign updateDrFall  = fall && (tapState == UPDATE_DR);
   assign updateIrFall  = fall && (tapState == UPDATE_IR);

   // ----------------------------------------
   // data and instruction shift stages
   // ----------------------------------------
   logic [CELL_COUNT-1:0]    cellShift;
   logic [CONTROL_WIDTH-1:0] controlShift;
   logic                     bypassShift;
   logic [IDENT_WIDTH-1:0]   identShift;
   logic                     inShiftDr;
   logic                     inShiftIr;
   logic                     selectedLsb;
   logic                     runOperation;
   logic [CELL_COUNT-1:0]    next_cells;

   assign inShiftDr = (tapState == SHIFT_DR);
   assign inShiftIr = (tapState == SHIFT_IR);
   // exactly one register in the path
   assign selectedLsb = inShiftIr                  ? instrShift[0] :
                        (dataSel == SEL_BOUNDARY)  ? cellShift[0] :
                        (dataSel == SEL_CONTROL)   ? controlShift[0] :
                        (dataSel == SEL_IDENT)     ? identShift[0] :
                                                     bypassShift;
   // operation only while idling under the run instruction
   assign runOperation = isRunt && (tapState == RUN_IDLE);
   // signature folds pins into cells; count increments cells
   // the count wraps past all ones with no carry reported
   assign next_cells = (operation == OPER_SIGNATURE) ?
                       ({cellShift[CELL_COUNT-2:0], ^cellShift} ^ pinSample) :
                       (operation == OPER_COUNT) ?
                       (cellShift + CELL_COUNT'(1)) : cellShift;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         instrShift <= INSTR_RESET;
      end else if (captureIrRise) begin
         instrShift <= INSTR_CAPTURE;
      end else if (shiftIrRise) begin
         instrShift <= {tdi, instrShift[INSTR_WIDTH-1:1]};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cellShift <= {CELL_COUNT{1'b1}};
      end else if (resetRise) begin
         cellShift[ENABLE_CELL_HIGH:ENABLE_CELL_LOW] <= 4'hF;
      end else if (captureDrRise && dataSel == SEL_BOUNDARY) begin
         cellShift <= pinSample;
      end else if (shiftDrRise && dataSel == SEL_BOUNDARY) begin
         cellShift <= {tdi, cellShift[CELL_COUNT-1:1]};
      end else if (rise && runOperation) begin
         cellShift <= next_cells;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         controlShift <= CONTROL_RESET;
      end else if (resetRise) begin
         controlShift <= CONTROL_RESET;
      end else if (shiftDrRise && dataSel == SEL_CONTROL) begin
         // capture leaves the control stage untouched
         controlShift <= {tdi, controlShift[CONTROL_WIDTH-1:1]};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bypassShift <= 1'b0;
      end else if (captureDrRise) begin
         bypassShift <= 1'b0;
      end else if (shiftDrRise && dataSel == SEL_BYPASS) begin
         bypassShift <= tdi;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         identShift <= IDENT_VALUE;
      end else if (captureDrRise) begin
         identShift <= IDENT_VALUE;
      end else if (shiftDrRise && dataSel == SEL_IDENT) begin
         identShift <= {tdi, identShift[IDENT_WIDTH-1:1]};
      end
   end

   // ----------------------------------------
   // falling-edge outputs and shadow latches
   // ----------------------------------------
   logic next_testMode;
   logic next_signatureMode;
   logic driveOut;

   // test mode only under test opcodes, never in the reset state
   assign next_testMode      = (tapState != TEST_LOGIC_RESET) && (isExtest || isRunt);
   // flag drops at the first fall after idle is left
   assign next_signatureMode = runOperation && (operation == OPER_SIGNATURE);
   // drive only in shift; the exit states float it again
   assign driveOut           = inShiftDr || inShiftIr;

   // every output except tapState moves on a falling edge only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         testDataOut   <= 1'b0;
         testDataOutEn <= 1'b0;
      end else if (fall) begin
         // drive lsb in shift; float elsewhere
         testDataOut   <= selectedLsb;
         testDataOutEn <= driveOut;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         activeInstr <= INSTR_RESET;
      end else if (resetFall) begin
         activeInstr <= INSTR_RESET;
      end else if (updateIrFall) begin
         activeInstr <= instrShift;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         operation <= CONTROL_RESET;
         cellDrive <= {CELL_COUNT{1'b1}};
      end else if (resetFall) begin
         operation <= CONTROL_RESET;
         cellDrive[ENABLE_CELL_HIGH:ENABLE_CELL_LOW] <= 4'hF;
      end else if (updateDrFall) begin
         if (dataSel == SEL_CONTROL) begin
            operation <= controlShift;
         end
         if (dataSel == SEL_BOUNDARY) begin
            cellDrive <= cellShift;
         end
      end
   end

   // test mode only leaves the transceiver disturbed under test opcodes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         testMode              <= 1'b0;
         parallelSignatureMode <= 1'b0;
      end else if (fall) begin
         testMode              <= next_testMode;
         parallelSignatureMode <= next_signatureMode;
      end
   end
endmodule // boundary_scan_tap_controller

// *** tb/scan_host_model.sv ***
// test bus host: makes the 320 ns test clock and drives mode and data
// assumes the caller enters each step at a falling clk edge
`timescale 1ns/1ps
module scan_host_model (
   input  wire logic clk,
   input  wire logic testDataOut,
   output logic      testClock,
   output logic      modeSelect,
   output logic      testDataIn
);
   // pulled-up pins idle high, clock parked high between frames
   initial begin
      testClock = 1'b1;
      modeSelect = 1'b1;
      testDataIn = 1'b1;
   end
   // ----------------------------------------
   // one test-clock period
   // ----------------------------------------
   // mode and data change on fall
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      testClock = 1'b0;
      modeSelect = tms;
      testDataIn = tdi;
      repeat (4) @(negedge clk);
      testClock = 1'b1;
      repeat (4) @(negedge clk);
      // sampled late in the period, well after the device has settled
      tdo = testDataOut;
   endtask
endmodule // scan_host_model

// *** tb/boundary_scan_tap_controller_sva.sv ***
// checker for the scan-port controller, bound to its ports
// assumes test-clock phases last at least 4 clk, as the bench makes them
`timescale 1ns/1ps
module boundary_scan_tap_controller_sva
   import scan_port_pkg::*;
(
   input wire logic                      clk,
   input wire logic                      rst,
   input wire logic                      testClock,
   input wire logic                      modeSelect,
   input wire logic                      testDataOut,
   input wire logic                      testDataOutEn,
   input wire logic [47:0]               cellDrive,
   input wire logic [7:0]                activeInstr,
   input wire logic [2:0]                operation,
   input wire logic                      parallelSignatureMode,
   input wire scan_port_pkg::tap_state_t tapState
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // run of high mode-select rises
   // ----------------------------------------
   logic [2:0] hiRun;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hiRun <= 3'h0;
      end else if ($rose(testClock)) begin
         hiRun <= !modeSelect ? 3'h0 : (hiRun == 3'h5) ? hiRun : hiRun + 3'h1;
      end
   end
   out_on_fall_a: assert property (
      $changed({testDataOut, testDataOutEn, activeInstr, operation}) |-> !$past(testClock, 3))
      else $error("output moved while test clock high");
   state_on_rise_a: assert property (
      $changed(tapState) |-> $past(testClock, 3))
      else $error("state moved while test clock low");
   select_dr_exit_a: assert property (
      $changed(tapState) && $past(tapState) == SELECT_DR |-> tapState inside {CAPTURE_DR, SELECT_IR})
      else $error("bad exit from data select");
   select_ir_leave_a: assert property (
      $rose(tapState == SELECT_IR) |-> ##[1:10] tapState != SELECT_IR)
      else $error("instruction select held");
   tlr_values_a: assert property (
      tapState == TEST_LOGIC_RESET [*8] |->
         activeInstr == 8'h81 && operation == 3'h2 && cellDrive[47:44] == 4'hF)
      else $error("reset state values wrong");
   five_high_a: assert property (
      hiRun == 3'h5 |-> ##[0:8] tapState == TEST_LOGIC_RESET)
      else $error("five high rises missed reset");
   shift_drive_a: assert property (
      $rose(tapState == SHIFT_DR) |-> ##[1:10] testDataOutEn)
      else $error("data out not driven in shift");
   exit_float_a: assert property (
      $rose(tapState == EXIT1_DR) |-> ##[1:10] !testDataOutEn)
      else $error("data out still driven after exit");
   drive_window_a: assert property (
      testDataOutEn |-> tapState inside {SHIFT_DR, SHIFT_IR, EXIT1_DR, EXIT1_IR})
      else $error("data out driven outside shift");
   ir_lead_bit_a: assert property (
      $rose(testDataOutEn) && tapState == SHIFT_IR |-> testDataOut)
      else $error("instruction capture lsb not one");
   signature_idle_a: assert property (
      parallelSignatureMode |-> tapState inside {RUN_IDLE, SELECT_DR})
      else $error("signature runs outside idle");
   cover property (tapState == PAUSE_DR);
   cover property (parallelSignatureMode);
   cover property (hiRun == 3'h5);
endmodule // boundary_scan_tap_controller_sva
bind boundary_scan_tap_controller boundary_scan_tap_controller_sva chk (.clk, .rst,
   .testClock, .modeSelect, .testDataOut, .testDataOutEn, .cellDrive, .activeInstr,
   .operation, .parallelSignatureMode, .tapState);

// *** tb/tb.sv ***
// self-checking bench: host model walks the scan port, results compared
// assumes the design package is compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
   import scan_port_pkg::*;
   // identity value is arbitrary
   localparam logic [31:0] IDENT = 32'h0000_5A01;
   logic                       clk, rst, testClock, modeSelect, testDataIn, t;
   logic                       testDataOut, testDataOutEn, testMode, psm;
   logic [47:0]                pinSample, cellDrive, din, dout;
   logic [7:0]                 activeInstr;
   logic [2:0]                 operation;
   scan_port_pkg::tap_state_t  tapState;
   int                         mismatches, check_count, cycles;
   logic [7:0]                 byp [3] = '{8'hFF, 8'h01, 8'h03};
   bit                         model [$];
   logic [7:0]                 exp8;
   wire                        tdoLine = testDataOutEn ? testDataOut : 1'bz;
   boundary_scan_tap_controller #(.IDENT_VALUE(IDENT)) dut (.clk, .rst, .testClock,
      .modeSelect, .testDataIn, .pinSample, .testDataOut, .testDataOutEn, .testMode,
      .cellDrive, .activeInstr, .operation, .parallelSignatureMode(psm), .tapState);
   scan_host_model host (.clk, .testDataOut(tdoLine), .testClock, .modeSelect, .testDataIn);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // hang guard, about fifteen times the expected run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // one scan from idle back to idle, optional pause
   // ----------------------------------------
   task automatic scan(input bit ir, input int n, input logic [47:0] d, input bit pz,
                       output logic [47:0] q);
      q = '0;
      host.step(1'b1, 1'b1, t);
      if (ir) host.step(1'b1, 1'b1, t);
      host.step(1'b0, 1'b1, t);
      host.step(1'b0, 1'b1, t);
      for (int i = 0; i < n; i++) begin
         host.step((i == n - 1) || (pz && i == n / 2), d[i], q[i]);
         `CHK("drive", 1'b1, testDataOutEn)
         if (pz && i == n / 2) begin
            host.step(1'b0, 1'b1, t);
            `CHK("float", 1'b0, testDataOutEn)
            repeat (3) host.step(1'b0, 1'b1, t);
            host.step(1'b1, 1'b1, t);
            host.step(1'b0, 1'b1, t);
         end
      end
      host.step(1'b1, 1'b1, t);
      host.step(1'b0, 1'b1, t);
   endtask
   initial begin
      rst = 1'b1;
      pinSample = '0;
      void'($urandom(32'hED99));
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      `CHK("state", TEST_LOGIC_RESET, tapState)
      `CHK("instr", 8'h81, activeInstr)
      `CHK("control", 3'h2, operation)
      `CHK("cells", 4'hF, cellDrive[47:44])
      `CHK("mode", 1'b0, testMode)
      host.step(1'b0, 1'b1, t);
      `CHK("idle", RUN_IDLE, tapState)
      scan(0, 32, 48'h0, 1, dout);
      `CHK("identity", IDENT, dout[31:0])
      scan(1, 8, 48'h09, 0, dout);
      `CHK("ir capture", 8'h81, dout[7:0])
      `CHK("instr", 8'h09, activeInstr)
      repeat (2) host.step(1'b0, 1'b1, t);
      `CHK("signature", 1'b1, psm)
      `CHK("test mode", 1'b1, testMode)
      // the flag only drops at the first fall after idle is left
      repeat (2) host.step(1'b1, 1'b1, t);
      `CHK("signature off", 1'b0, psm)
      for (int i = 0; i < 10; i++) host.step(1'($urandom), 1'($urandom), t);
      repeat (5) host.step(1'b1, 1'b1, t);
      `CHK("five high", TEST_LOGIC_RESET, tapState)
      host.step(1'b1, 1'b1, t);
      `CHK("instr", 8'h81, activeInstr)
      `CHK("control", 3'h2, operation)
      `CHK("cells", 4'hF, cellDrive[47:44])
      host.step(1'b0, 1'b1, t);
      scan(1, 8, 48'h0A, 0, dout);
      scan(0, 3, 48'h6, 0, dout);
      `CHK("control keep", 3'h2, dout[2:0])
      `CHK("control", 3'h6, operation)
      pinSample = {16'($urandom), $urandom};
      scan(1, 8, 48'h82, 0, dout);
      din = {16'($urandom), $urandom};
      scan(0, 48, din, 0, dout);
      `CHK("sample", pinSample, dout)
      `CHK("cell update", din, cellDrive)
      foreach (byp[k]) begin
         scan(1, 8, {40'h0, byp[k]}, 0, dout);
         din = 48'($urandom);
         scan(0, 8, din, 0, dout);
         // one-bit path model: a captured zero leads, data follows one late
         model.delete();
         model.push_back(1'b0);
         for (int i = 0; i < 8; i++) begin
            model.push_back(din[i]);
            exp8[i] = model.pop_front();
         end
         `CHK("bypass", exp8, dout[7:0])
      end
      results();
   end
endmodule // tb
